// ### rtcl_defs.svh
// Address map, field positions and reset values of the time latch block.
// Included by the field comparator and the time latch module; holds definitions only.
`ifndef RTCL_DEFS_SVH
`define RTCL_DEFS_SVH

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define RTCL_ADDR_HUND      5'h00
`define RTCL_ADDR_ALARM_HI  2'h1
`define RTCL_ADDR_STATUS    5'h10
`define RTCL_ADDR_CMD       5'h11

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTCL_BIT_ALARM      0
`define RTCL_BIT_ANY        7
`define RTCL_BIT_GIE        4
`define RTCL_BIT_TEST       5
`define RTCL_BIT_FMASK      7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RTCL_CMD_RST        8'h00
`define RTCL_IMASK_RST      7'h00
`define RTCL_STATUS_RST     8'h00
`define RTCL_BYTE_RST       8'h00

`endif

// ### rtcl_field_cmp.sv
// One alarm field comparator: live counter byte against stored alarm byte.
// Assumes bit 7 of the alarm byte is that field's mask flag.
`timescale 1ns/1ps
`default_nettype none
`include "rtcl_defs.svh"

module rtcl_field_cmp #(
  parameter bit ZERO_WHEN_MASKED = 1'b0
) (
  input  wire logic [7:0] live,
  input  wire logic [7:0] alarm,
  output logic            hit
);

  // Masked field drops out, or stands for 00 where asked
  always_comb begin
    if (alarm[`RTCL_BIT_FMASK]) begin
      hit = ZERO_WHEN_MASKED ? (live == 8'h00) : 1'b1;
    end else begin
      hit = (live == {1'b0, alarm[6:0]});
    end
  end

endmodule
`default_nettype wire

// ### rtcl_host.sv
// Host side of the register bus: one task for a read or write access.
// Assumes clk is the block clock and the block samples on rising edges.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Host bus model
// ------------------------------
module rtcl_host (
  input  wire logic       clk,
  output var  logic       cs_n,
  output var  logic       rd_n,
  output var  logic       wr_n,
  output var  logic [4:0] addr,
  output var  logic [7:0] data_in
);
  // Idle bus at time zero
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 5'h00;
    data_in = 8'h00;
  end

  // No ready pin, so the strobe is held a fixed two cycles
  task automatic acc(input bit w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= w;
    wr_n <= !w;
    addr <= a;
    data_in <= d;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    data_in <= ~d; // Released data must not look valid
    @(posedge clk); // Idle gap between accesses
  endtask
endmodule
`default_nettype wire

// ### rtcl_pkg.sv
// Types shared by the time latch block and its self-checking bench.
// Assumes rtcl_defs.svh supplies the numeric constants.
`default_nettype none
package rtcl_pkg;

  // Eight byte-wide time fields, index = register address low bits
  typedef logic [7:0][7:0] rtcl_bank_t;

  // Whole state of the top module, one register
  typedef struct packed {
    logic       prev_rd;
    logic       prev_wr;
    logic [7:0] rd_data;
    logic       rd_oe;
    rtcl_bank_t latch;
    rtcl_bank_t alarm;
    logic [6:0] imask;
    logic [7:0] cmd;
    logic [7:0] status;
    logic       irq_oe;
    logic       match_prev;
    logic [7:0] load_strobe;
    logic [7:0] load_data;
  } rtcl_state_t;

endpackage
`default_nettype wire

// ### rtcl_time_latch.sv
// Bus side of the clock: time read latch, alarm RAM, command and mask
// registers, event flags and the open-drain interrupt pin.
// Assumes the counter chain outside supplies live bytes and tick pulses,
// and bus pins already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "rtcl_defs.svh"

// Summary of operation
// - Hundredths read latches the seven other counters
// - Hundredths read returns live value, unlatched
// - Latched values hold until next hundredths read
// - Alarm RAM reads return stored bytes directly
// - Status flags each counter increment, mask-independent
// - Status register clears right after each read
// - Bit 7 any interrupt; bit 0 alarm source
// - Status read releases the interrupt pin
// - Periodic needs global enable and mask bit
// - Periodic fires on each enabled counter increment
// - Alarm needs global enable and alarm mask
// - Alarm match sets bits 0,7 and pin
// - Masked alarm fields excluded from comparison
// - Masked hundredths field compares as 00
// - Low backup or bad supply disables bus
// - Mask value 08H enables only one-second interrupt
// - Command bit 5 selects counter test mode
module rtcl_time_latch
  import rtcl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic       supply_valid,
  input  wire logic       standby_supply_sense,
  input  wire rtcl_bank_t cnt_live,
  input  wire logic [6:1] cnt_tick,
  output logic      [7:0] cnt_load,
  output logic      [7:0] cnt_load_data,
  output logic            test_mode_bit,
  output logic            irq_out,
  output logic            irq_oe
);

  // --------------------------------------------------------------------
  // Alarm comparators
  // --------------------------------------------------------------------
  // State copy declared ahead of the comparators that read it
  rtcl_state_t s_reg;
  rtcl_state_t s_next;
  logic [7:0]  field_hit;
  logic        alarm_match;

  for (genvar g = 0; g < 8; g++) begin : g_cmp
    rtcl_field_cmp #(
      .ZERO_WHEN_MASKED (g == 0)
    ) u_cmp (
      .live  (cnt_live[g]),
      .alarm (s_reg.alarm[g]),
      .hit   (field_hit[g])
    );
  end
  assign alarm_match = &field_hit;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic        bus_en;
  logic        rd_act;
  logic        wr_act;
  logic        rd_go;
  logic        wr_go;
  logic        global_irq_enable;
  logic        alarm_edge;
  logic        alarm_fire;
  logic        periodic_fire;
  logic [7:0]  new_ev;
  logic        status_rd;
  logic        hund_rd;

  // Bus strobes act once, on the first cycle of an access
  always_comb begin
    bus_en            = supply_valid & ~standby_supply_sense;
    rd_act            = bus_en & ~cs_n & ~rd_n;
    wr_act            = bus_en & ~cs_n & ~wr_n;
    rd_go             = rd_act & ~s_reg.prev_rd;
    wr_go             = wr_act & ~s_reg.prev_wr;
    hund_rd           = rd_go & (addr == `RTCL_ADDR_HUND);
    status_rd         = rd_go & (addr == `RTCL_ADDR_STATUS);
    global_irq_enable = s_reg.cmd[`RTCL_BIT_GIE];
    // Rising edge only, so one match gives one interrupt
    alarm_edge        = alarm_match & ~s_reg.match_prev;
    alarm_fire        = alarm_edge & global_irq_enable & s_reg.imask[0];
    periodic_fire     = global_irq_enable & (|(cnt_tick & s_reg.imask[6:1]));
    new_ev                    = {1'b0, cnt_tick, 1'b0};
    new_ev[`RTCL_BIT_ALARM]   = alarm_fire;
    new_ev[`RTCL_BIT_ANY]     = alarm_fire | periodic_fire;
  end

  always_comb begin
    s_next             = s_reg;
    s_next.prev_rd     = rd_act;
    s_next.prev_wr     = wr_act;
    s_next.rd_oe       = rd_act;
    s_next.match_prev  = alarm_match;
    s_next.load_strobe = 8'h00;
    // Read-clear; events of this very cycle land after the clear
    if (status_rd) begin
      s_next.status = new_ev;
    end else begin
      s_next.status = s_reg.status | new_ev;
    end
    // Pin release loses to a new interrupt in the same cycle
    if (new_ev[`RTCL_BIT_ANY]) begin
      s_next.irq_oe = 1'b1;
    end else if (status_rd) begin
      s_next.irq_oe = 1'b0;
    end
    // Snapshot of the seven slower counters
    if (hund_rd) begin
      for (int i = 1; i < 8; i++) begin
        s_next.latch[i] = cnt_live[i];
      end
    end
    // Read data path
    if (rd_go) begin
      if (addr == `RTCL_ADDR_HUND) begin
        s_next.rd_data = cnt_live[0];
      end else if (addr[4:3] == 2'h0) begin
        s_next.rd_data = s_reg.latch[addr[2:0]];
      end else if (addr[4:3] == `RTCL_ADDR_ALARM_HI) begin
        s_next.rd_data = s_reg.alarm[addr[2:0]];
      end else if (addr == `RTCL_ADDR_STATUS) begin
        s_next.rd_data = s_reg.status;
      end else if (addr == `RTCL_ADDR_CMD) begin
        s_next.rd_data = s_reg.cmd;
      end else begin
        s_next.rd_data = 8'h00;
      end
    end
    // Writes: counters go out to the chain, the rest stored here
    if (wr_go) begin
      if (addr[4:3] == 2'h0) begin
        s_next.load_strobe[addr[2:0]] = 1'b1;
        s_next.load_data              = data_in;
      end else if (addr[4:3] == `RTCL_ADDR_ALARM_HI) begin
        s_next.alarm[addr[2:0]] = data_in;
      end else if (addr == `RTCL_ADDR_STATUS) begin
        s_next.imask = data_in[6:0];
      end else if (addr == `RTCL_ADDR_CMD) begin
        s_next.cmd = data_in;
      end
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg.prev_rd     <= 1'b0;
      s_reg.prev_wr     <= 1'b0;
      s_reg.rd_data     <= `RTCL_BYTE_RST;
      s_reg.rd_oe       <= 1'b0;
      s_reg.latch       <= '0;
      s_reg.alarm       <= '0;
      s_reg.imask       <= `RTCL_IMASK_RST;
      s_reg.cmd         <= `RTCL_CMD_RST;
      s_reg.status      <= `RTCL_STATUS_RST;
      s_reg.irq_oe      <= 1'b0;
      s_reg.match_prev  <= 1'b0;
      s_reg.load_strobe <= 8'h00;
      s_reg.load_data   <= `RTCL_BYTE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register; irq_out is tied low
  assign data_out      = s_reg.rd_data;
  assign data_oe       = s_reg.rd_oe;
  assign cnt_load      = s_reg.load_strobe;
  assign cnt_load_data = s_reg.load_data;
  assign test_mode_bit = s_reg.cmd[`RTCL_BIT_TEST];
  assign irq_out       = 1'b0; // Open drain only ever pulls low
  assign irq_oe        = s_reg.irq_oe;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence sq_hund_read;
    rd_go && (addr == `RTCL_ADDR_HUND);
  endsequence

  sequence sq_alarm_edge;
    alarm_match && !s_reg.match_prev && global_irq_enable && s_reg.imask[0];
  endsequence

  a_live_hund: assert property (@(posedge clk) disable iff (srst)
    sq_hund_read |=> data_out == $past(cnt_live[0]))
    else $error("hundredths read not live");
  a_latch_take: assert property (@(posedge clk) disable iff (srst)
    sq_hund_read |=> s_reg.latch[3] == $past(cnt_live[3]))
    else $error("latch not captured");
  a_latch_hold: assert property (@(posedge clk) disable iff (srst)
    !(rd_go && addr == `RTCL_ADDR_HUND) |=> $stable(s_reg.latch))
    else $error("latch changed without hundredths read");
  a_alarm_read: assert property (@(posedge clk) disable iff (srst)
    rd_go && addr[4:3] == 2'h1 |=> data_out == $past(s_reg.alarm[addr[2:0]]))
    else $error("alarm read mismatch");
  a_status_clr: assert property (@(posedge clk) disable iff (srst)
    status_rd && cnt_tick == 6'h00 && !alarm_fire |=> s_reg.status == 8'h00)
    else $error("status not cleared by read");
  a_irq_release: assert property (@(posedge clk) disable iff (srst)
    status_rd && !new_ev[7] ##1 !new_ev[7] |=> !irq_oe [*1])
    else $error("irq not released");
  a_tick_flag: assert property (@(posedge clk) disable iff (srst)
    cnt_tick[1] |=> s_reg.status[1])
    else $error("increment not flagged");
  a_periodic: assert property (@(posedge clk) disable iff (srst)
    cnt_tick[3] && s_reg.cmd[4] && s_reg.imask[3] |=> irq_oe && s_reg.status[7])
    else $error("periodic interrupt missing");
  a_no_gie: assert property (@(posedge clk) disable iff (srst)
    !s_reg.cmd[4] && !irq_oe |=> !irq_oe)
    else $error("interrupt without global enable");
  a_alarm_fire: assert property (@(posedge clk) disable iff (srst)
    sq_alarm_edge |=> s_reg.status[0] && s_reg.status[7] && irq_oe)
    else $error("alarm interrupt missing");
  a_bus_off: assert property (@(posedge clk) disable iff (srst)
    !bus_en |=> !data_oe ##1 !data_oe or bus_en)
    else $error("bus driven while disabled");

endmodule
`default_nettype wire

// ### rtcl_time_latch_test.sv
// Self-checking bench for the time latch block.
// Assumes rtcl_host.sv as the bus master and the bench as counter chain.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
// ------------------------------
// Bench top
// ------------------------------
module rtcl_time_latch_test;
  import rtcl_pkg::*;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       supply_valid = 1'b1;
  logic       standby_supply_sense = 1'b0;
  rtcl_bank_t live = '0;
  rtcl_bank_t snap;
  rtcl_bank_t nxt;
  logic [6:1] tick = '0;
  logic       cs_n, rd_n, wr_n, data_oe, test_mode_bit, irq_out, irq_oe;
  logic [4:0] addr;
  logic [7:0] data_in, data_out, cnt_load, cnt_load_data;
  logic       prev_oe = 1'b0;
  logic [15:0] expq[$];
  int         bad_count = 0;
  int         checks = 0;
  integer     seed = 32'h6e89;

  always #20 clk = ~clk;

  rtcl_host i_host (.clk, .cs_n, .rd_n, .wr_n, .addr, .data_in);
  rtcl_time_latch i_dut (.clk, .srst, .cs_n, .rd_n, .wr_n, .addr, .data_in,
    .data_out, .data_oe, .supply_valid, .standby_supply_sense, .cnt_live(live),
    .cnt_tick(tick), .cnt_load, .cnt_load_data, .test_mode_bit, .irq_out, .irq_oe);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Oldest note against each read answer or counter load
  // Pop once; the macro names its expected value twice
  task automatic take(input logic [15:0] got);
    logic [15:0] exp_v;
    if (expq.size() == 0) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, 16'h0000);
    end else begin
      exp_v = expq.pop_front();
      `CHK(got, exp_v)
    end
  endtask
  // Skip reset cycles, where the load strobe is still unknown
  always @(posedge clk) begin
    prev_oe <= data_oe;
    if (data_oe === 1'b1 && prev_oe !== 1'b1) take({8'h00, data_out});
    if (!srst && cnt_load !== 8'h00) take({cnt_load, cnt_load_data});
  end

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    expq.push_back({8'h00, e});
    i_host.acc(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_host.acc(1'b1, a, d);
  endtask
  task automatic pulse(input int n);
    @(posedge clk);
    tick <= 6'(1) << (n - 1);
    @(posedge clk);
    tick <= '0;
  endtask
  task automatic settle(input logic e);
    repeat (3) @(posedge clk);
    `CHK(irq_oe, e)
    `CHK(irq_out, 1'b0)
  endtask

  // Cut a hang short
  initial begin
    #(40 * 5000);
    bad_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK({data_oe, irq_oe, cnt_load}, 10'h000)
    live <= {$random(seed), $random(seed)};
    @(posedge clk);
    snap = live;
    rd(5'h00, snap[0]);
    nxt = {$random(seed), $random(seed)};
    nxt[3] = 8'h06; // Keeps the alarm from matching early
    live <= nxt;
    @(posedge clk);
    for (int i = 1; i < 8; i++) rd(i[4:0], snap[i]);
    rd(5'h00, live[0]);
    $display("test snapshot done");
    expq.push_back({8'h08, 8'h3C});
    wr(5'h03, 8'h3C);
    wr(5'h11, 8'h30);
    `CHK(test_mode_bit, 1'b1)
    rd(5'h1F, 8'h00);
    pulse(3);
    rd(5'h10, 8'h08);
    rd(5'h10, 8'h00);
    $display("test status done");
    wr(5'h10, 8'h08);
    pulse(2);
    settle(1'b0);
    pulse(3);
    settle(1'b1);
    rd(5'h10, 8'h8C);
    settle(1'b0);
    expq.push_back(16'h0000);
    fork
      i_host.acc(1'b0, 5'h10, 8'h00);
      pulse(3);
    join
    rd(5'h10, 8'h88);
    $display("test periodic done");
    wr(5'h10, 8'h01);
    for (int i = 8; i < 16; i++) wr(i[4:0], (i == 11) ? 8'h05 : 8'h80);
    rd(5'h0B, 8'h05);
    nxt = live;
    nxt[3] = 8'h05;
    nxt[0] = 8'h01;
    live <= nxt;
    settle(1'b0);
    live[0] <= 8'h00;
    settle(1'b1);
    rd(5'h10, 8'h81);
    settle(1'b0);
    $display("test alarm done");
    // Both disable causes: reads must stay silent, writes be dropped
    for (int i = 0; i < 2; i++) begin
      supply_valid <= i[0];
      standby_supply_sense <= i[0];
      i_host.acc(1'b0, 5'h00, 8'h00);
      wr(5'h11, 8'h00);
      `CHK(test_mode_bit, 1'b1)
    end
    supply_valid <= 1'b1;
    standby_supply_sense <= 1'b0;
    $display("test disable done");
    repeat (3) @(posedge clk);
    `CHK(expq.size(), 0)
    give_verdict();
  end
endmodule
`default_nettype wire
